// File: src/lms_regs.svh
// Timing figures and derived cycle counts for the LED driver mode sequencer.
// Assumes the system clock is the running internal oscillator at 125 MHz.
`ifndef LMS_REGS_SVH
`define LMS_REGS_SVH

// ----------------------------------------------------------------------------
// Clock rate
// ----------------------------------------------------------------------------
`define LMS_CLK_MHZ             125

// ----------------------------------------------------------------------------
// Times in microseconds, as printed
// ----------------------------------------------------------------------------
`define LMS_T_LOGIC_UV_US       25
`define LMS_T_LIMP_US           1150
`define LMS_T_WD_TIMEOUT_US     75000
`define LMS_T_RESTART_US        100000
`define LMS_T_TOGGLE_US         2100000

// ----------------------------------------------------------------------------
// Cycle counts (microseconds times MHz is exact, so no rounding is needed)
// ----------------------------------------------------------------------------
`define LMS_LOGIC_UV_CYC        (`LMS_T_LOGIC_UV_US * `LMS_CLK_MHZ)
`define LMS_LIMP_CYC            (`LMS_T_LIMP_US * `LMS_CLK_MHZ)
`define LMS_WD_TIMEOUT_CYC      (`LMS_T_WD_TIMEOUT_US * `LMS_CLK_MHZ)
`define LMS_RESTART_CYC         (`LMS_T_RESTART_US * `LMS_CLK_MHZ)
`define LMS_TOGGLE_CYC          (`LMS_T_TOGGLE_US * `LMS_CLK_MHZ)

// ----------------------------------------------------------------------------
// Channel layout
// ----------------------------------------------------------------------------
`define LMS_NUM_CH              8
`define LMS_NUM_LINES           4
`define LMS_DIRECT_MASK         8'h77

`endif

// File: src/lms_pkg.sv
// Types shared by the LED driver mode sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package lms_pkg;

  // --------------------------------------------------------------------------
  // Operating modes, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LMS_STANDBY = 3'b001,
    LMS_NORMAL  = 3'b010,
    LMS_FAIL    = 3'b100
  } lms_mode_e;

  typedef logic [31:0] lms_count_t;

endpackage : lms_pkg

// File: src/lms_sync.sv
// Two-stage level synchroniser, any width.
// Assumes each bit is an independent level; words must not pass through here.
`timescale 1ns/10ps
`default_nettype none

module lms_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  // --------------------------------------------------------------------------
  // Stages
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;

  // First stage is read by the second only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : lms_sync

`default_nettype wire

// File: src/lms_timer.sv
// Run-length timer: done goes high after run has stood for limit cycles.
// Assumes limit is at least one and stays steady while run is high.
`timescale 1ns/10ps
`default_nettype none

module lms_timer
  import lms_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire lms_count_t limit,
  output var  logic       done
);

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  lms_count_t count_r;
  wire        at_end = (count_r >= (limit - 32'h0000_0001));

  // Dropping run restarts the count, which makes the timer retriggerable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_r <= '0;
      done    <= 1'b0;
    end else if (!run) begin
      count_r <= '0;
      done    <= 1'b0;
    end else begin
      count_r <= at_end ? count_r : count_r + 32'h0000_0001;
      done    <= at_end;
    end
  end

endmodule : lms_timer

`default_nettype wire

// File: src/lms_sequencer.sv
// Operating-mode sequencer of an eight-channel high-side LED switch.
// Assumes pins and sensor levels are asynchronous, normal_out_request comes
// from logic on clk_sys, and the serial decoder runs on clk_link.
`timescale 1ns/10ps
`default_nettype none
`include "lms_regs.svh"

// Notes on behaviour
// - Idle inputs and enable keep standby, core off
// - Wake powers core, resets registers, goes normal
// - Normal entry needs supply, limp low, and an enable edge or a high input other than 4 and 8
// - Normal mode enables serial port, control, diagnostics
// - Normal left on undervoltage, enable, serial, limp, watchdog
// - Fail mode: outputs follow inputs, 4 and 8 off
// - Fail flag plus cause flag reported
// - Fail entry delays per cause
// - Enable fall with input high blocks watchdog
// - Serial port live in fail unless undervoltage
// - Status flags kept into fail mode
// - Other registers kept, PWM off in fail
// - Mode control reset and locked in fail
// - Current sense uses low resistance ratio
// - Overcurrent: off, restart after delay, repeat
// - Supply fault: off, restore after delay
// - Over-temperature latches off until a change into normal or standby
// - Clear flags, then watchdog 0 then 1 exits
// - Warm reset leaves core supply and oscillator
// - Leaving fail resets all registers
// - Input monostable keeps device awake after edges
module lms_sequencer
  import lms_pkg::*;
#(
  parameter lms_count_t LIMP_CYC       = `LMS_LIMP_CYC,
  parameter lms_count_t WD_TIMEOUT_CYC = `LMS_WD_TIMEOUT_CYC,
  parameter lms_count_t RESTART_CYC    = `LMS_RESTART_CYC,
  parameter lms_count_t TOGGLE_CYC     = `LMS_TOGGLE_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_link,
  input  wire logic [7:0] direct_drive_inputs,
  input  wire logic       enable_pin,
  input  wire logic       limp_pin,
  input  wire logic       logic_undervoltage,
  input  wire logic [7:0] channel_overcurrent,
  input  wire logic [3:0] supply_line_undervoltage,
  input  wire logic [3:0] supply_line_overvoltage,
  input  wire logic [7:0] over_temperature_shutdown,
  input  wire logic [7:0] normal_out_request,
  input  wire logic       link_cmd_valid,
  input  wire logic       link_cmd_wd,
  input  wire logic       link_cmd_clear,
  input  wire logic       link_spi_fail,
  output var  logic [7:0] power_outputs,
  output var  logic       core_enable,
  output var  logic       cold_reset,
  output var  logic       warm_reset,
  output var  logic       normal_mode,
  output var  logic       spi_enable,
  output var  logic       pwm_enable,
  output var  logic       diag_enable,
  output var  logic       cs_low_ron,
  output var  logic       mode_ctrl_reset,
  output var  logic       mode_ctrl_wprot,
  output var  logic       wake_pending,
  output var  logic       fail_mode_flag,
  output var  logic       logic_undervoltage_flag,
  output var  logic       serial_failure_flag,
  output var  logic       watchdog_check_error_flag,
  output var  logic       limp_flag,
  output var  logic       link_fail_mode_flag
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [7:0] dd_s;
  logic       en_s;
  logic       limp_s;
  logic       uv_s;
  logic [7:0] oc_s;
  logic [3:0] line_uv_s;
  logic [3:0] line_ov_s;
  logic [7:0] ots_s;

  lms_sync #(.WIDTH(35)) u_pin_sync (
    .clk   (clk_sys),
    .reset (reset),
    .d     ({direct_drive_inputs, enable_pin, limp_pin, logic_undervoltage, channel_overcurrent,
             supply_line_undervoltage, supply_line_overvoltage, over_temperature_shutdown}),
    .q     ({dd_s, en_s, limp_s, uv_s, oc_s, line_uv_s, line_ov_s, ots_s})
  );

  // --------------------------------------------------------------------------
  // Link domain: command and failure events as toggles
  // --------------------------------------------------------------------------
  logic cmd_tgl_r;
  logic cmd_wd_r;
  logic cmd_clr_r;
  logic fail_tgl_r;

  // Payload is held until the next frame, long after the toggle crosses
  always_ff @(posedge clk_link or posedge reset) begin
    if (reset) begin
      cmd_tgl_r  <= 1'b0;
      cmd_wd_r   <= 1'b0;
      cmd_clr_r  <= 1'b0;
      fail_tgl_r <= 1'b0;
    end else begin
      if (link_cmd_valid) begin
        cmd_tgl_r <= ~cmd_tgl_r;
        cmd_wd_r  <= link_cmd_wd;
        cmd_clr_r <= link_cmd_clear;
      end
      if (link_spi_fail) begin
        fail_tgl_r <= ~fail_tgl_r;
      end
    end
  end

  // Fail flag back to the serial side for the status word
  lms_sync #(.WIDTH(1)) u_link_stat_sync (
    .clk   (clk_link),
    .reset (reset),
    .d     (fail_mode_flag),
    .q     (link_fail_mode_flag)
  );

  // --------------------------------------------------------------------------
  // System domain: event detection from the toggles
  // --------------------------------------------------------------------------
  logic cmd_tgl_s;
  logic fail_tgl_s;
  logic cmd_tgl_d_r;
  logic fail_tgl_d_r;
  logic cmd_wd_s;
  logic cmd_clr_s;

  lms_sync #(.WIDTH(2)) u_evt_sync (
    .clk   (clk_sys),
    .reset (reset),
    .d     ({cmd_tgl_r, fail_tgl_r}),
    .q     ({cmd_tgl_s, fail_tgl_s})
  );

  // Payload sampled again so it is read only from flops on this clock
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_tgl_d_r  <= 1'b0;
      fail_tgl_d_r <= 1'b0;
      cmd_wd_s     <= 1'b0;
      cmd_clr_s    <= 1'b0;
    end else begin
      cmd_tgl_d_r  <= cmd_tgl_s;
      fail_tgl_d_r <= fail_tgl_s;
      cmd_wd_s     <= cmd_wd_r;
      cmd_clr_s    <= cmd_clr_r;
    end
  end

  wire cmd_evt   = cmd_tgl_s ^ cmd_tgl_d_r;
  wire serial_failure_flag_evt  = fail_tgl_s ^ fail_tgl_d_r;
  wire cmd_clear = cmd_evt & cmd_clr_s;

  // --------------------------------------------------------------------------
  // Mode state and decodes
  // --------------------------------------------------------------------------
  lms_mode_e  mode_r;
  lms_mode_e  mode_nxt;
  logic       en_d_r;
  logic       wd_last_r;
  logic       wd_bad_r;
  logic       exit_step_r;
  logic       exit_step_nxt;
  logic       mono_armed_r;
  logic       uv_done;
  logic       limp_done;
  logic       wd_done;
  logic       mono_done;

  wire is_standby = (mode_r == LMS_STANDBY);
  wire is_normal  = (mode_r == LMS_NORMAL);
  wire is_fail    = (mode_r == LMS_FAIL);
  wire [7:0] dd_m = dd_s & `LMS_DIRECT_MASK;
  wire any_in     = |dd_m;
  wire en_rise    = en_s & ~en_d_r;
  wire wake_hold  = any_in | (mono_armed_r & ~mono_done);
  wire start_ok   = ~uv_s & ~limp_s;
  wire wake_req   = en_rise | any_in;
  wire wd_kick    = is_normal & cmd_evt & en_s & ~wd_bad_r & (cmd_wd_s != wd_last_r);
  wire wd_wrong   = is_normal & cmd_evt & (cmd_wd_s == wd_last_r);
  wire flags_any  = logic_undervoltage_flag | serial_failure_flag | watchdog_check_error_flag | limp_flag;
  wire exit_ok    = en_s & ~flags_any;
  wire to_fail    = is_normal & (serial_failure_flag_evt | uv_done | wd_done | limp_done);
  wire idle_drop  = ~en_s & ~wake_hold;
  wire warm_go    = is_fail & cmd_evt & exit_step_r & cmd_wd_s & exit_ok;

  // --------------------------------------------------------------------------
  // Delay timers on the running oscillator
  // --------------------------------------------------------------------------
  // Undervoltage must persist for the detection time before it counts
  lms_timer u_uv_tmr (
    .clk   (clk_sys),
    .reset (reset),
    .run   (uv_s & ~is_standby),
    .limit (`LMS_LOGIC_UV_CYC),
    .done  (uv_done)
  );

  lms_timer u_limp_tmr (
    .clk   (clk_sys),
    .reset (reset),
    .run   (limp_s & ~is_standby),
    .limit (LIMP_CYC),
    .done  (limp_done)
  );

  // A good toggle with enable high restarts the watchdog; a bad one just stops refreshes
  lms_timer u_wd_tmr (
    .clk   (clk_sys),
    .reset (reset),
    .run   (is_normal & ~wd_kick),
    .limit (WD_TIMEOUT_CYC),
    .done  (wd_done)
  );

  // Retriggerable: every high input except 4 and 8 holds the count at zero
  lms_timer u_mono_tmr (
    .clk   (clk_sys),
    .reset (reset),
    .run   (~any_in),
    .limit (TOGGLE_CYC),
    .done  (mono_done)
  );

  // --------------------------------------------------------------------------
  // Next mode
  // --------------------------------------------------------------------------
  always_comb begin
    mode_nxt      = mode_r;
    exit_step_nxt = exit_step_r;
    case (mode_r)
      LMS_STANDBY: begin
        if (wake_req && start_ok) begin
          mode_nxt = LMS_NORMAL;
        end
      end
      LMS_NORMAL: begin
        exit_step_nxt = 1'b0;
        if (to_fail) begin
          mode_nxt = LMS_FAIL;
        end else if (idle_drop) begin
          mode_nxt = LMS_STANDBY;
        end
      end
      LMS_FAIL: begin
        if (warm_go) begin
          mode_nxt      = LMS_NORMAL;
          exit_step_nxt = 1'b0;
        end else if (idle_drop) begin
          mode_nxt      = LMS_STANDBY;
          exit_step_nxt = 1'b0;
        end else if (cmd_evt) begin
          exit_step_nxt = exit_ok & ~cmd_wd_s;
        end
      end
      default: begin
        mode_nxt      = LMS_STANDBY;
        exit_step_nxt = 1'b0;
      end
    endcase
  end

  // Mode and watchdog tracking
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_r       <= LMS_STANDBY;
      en_d_r       <= 1'b0;
      exit_step_r  <= 1'b0;
      mono_armed_r <= 1'b0;
    end else begin
      mode_r       <= mode_nxt;
      en_d_r       <= en_s;
      exit_step_r  <= exit_step_nxt;
      mono_armed_r <= mono_armed_r | any_in;
    end
  end

  // First expected toggle after entering normal is a zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wd_last_r <= 1'b1;
      wd_bad_r  <= 1'b0;
    end else if (!is_normal) begin
      wd_last_r <= 1'b1;
      wd_bad_r  <= 1'b0;
    end else begin
      wd_last_r <= wd_kick ? cmd_wd_s : wd_last_r;
      wd_bad_r  <= wd_bad_r | wd_wrong;
    end
  end

  // --------------------------------------------------------------------------
  // Status flags: hardware set wins over a read-and-clear
  // --------------------------------------------------------------------------
  wire set_uv   = uv_done & ~is_standby;
  wire set_serial_failure_flag = serial_failure_flag_evt & ~is_standby;
  wire set_wd   = wd_done & is_normal;
  wire set_limp = limp_done & ~is_standby;

  // Flags survive fail entry; only a clear or a register reset drops them
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      logic_undervoltage_flag   <= 1'b0;
      serial_failure_flag       <= 1'b0;
      watchdog_check_error_flag <= 1'b0;
      limp_flag                 <= 1'b0;
    end else begin
      logic_undervoltage_flag   <= set_uv | (logic_undervoltage_flag & ~cmd_clear);
      serial_failure_flag       <= set_serial_failure_flag | (serial_failure_flag & ~cmd_clear);
      watchdog_check_error_flag <= set_wd | (watchdog_check_error_flag & ~cmd_clear);
      limp_flag                 <= set_limp | (limp_flag & ~cmd_clear);
    end
  end

  // --------------------------------------------------------------------------
  // Per-channel auto restart and thermal latch
  // --------------------------------------------------------------------------
  logic [7:0] drive_nxt;
  logic [7:0] ots_latch_r;
  logic [7:0] restart_r;
  wire        mode_enter_ok = (mode_nxt != mode_r) & (mode_nxt != LMS_FAIL);

  genvar ch;
  generate
    for (ch = 0; ch < `LMS_NUM_CH; ch++) begin : g_ch
      logic restart_done;
      wire  line_fault = line_uv_s[ch/2] | line_ov_s[ch/2];
      wire  fault_hit  = is_fail & dd_m[ch] & (oc_s[ch] | line_fault);

      // Supply faults hold the count until the line recovers
      lms_timer u_restart_tmr (
        .clk   (clk_sys),
        .reset (reset),
        .run   (is_fail & restart_r[ch] & ~line_fault),
        .limit (RESTART_CYC),
        .done  (restart_done)
      );

      // Off on a fault, on again after the delay, looping while it persists
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          restart_r[ch]   <= 1'b0;
          ots_latch_r[ch] <= 1'b0;
        end else begin
          restart_r[ch]   <= is_fail & (fault_hit | (restart_r[ch] & ~restart_done));
          ots_latch_r[ch] <= ~mode_enter_ok & (ots_latch_r[ch] | (ots_s[ch] & ~is_standby));
        end
      end

      // Fail drive follows the pin; normal drive comes from the control logic
      assign drive_nxt[ch] = ~ots_latch_r[ch] & ~ots_s[ch] &
                             ((is_fail & dd_m[ch] & ~restart_r[ch] & ~fault_hit) |
                              (is_normal & normal_out_request[ch]));
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  wire into_fail   = (mode_nxt == LMS_FAIL) & ~is_fail;
  wire wake_normal = is_standby & (mode_nxt == LMS_NORMAL);

  // Power outputs and mode-derived enables
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      power_outputs  <= 8'h00;
      normal_mode    <= 1'b0;
      fail_mode_flag <= 1'b0;
      spi_enable     <= 1'b0;
      pwm_enable     <= 1'b0;
      diag_enable    <= 1'b0;
      cs_low_ron     <= 1'b0;
    end else begin
      power_outputs  <= drive_nxt & {8{mode_nxt != LMS_STANDBY}};
      normal_mode    <= (mode_nxt == LMS_NORMAL);
      fail_mode_flag <= (mode_nxt == LMS_FAIL);
      spi_enable     <= (mode_nxt == LMS_NORMAL) | ((mode_nxt == LMS_FAIL) & ~uv_s);
      pwm_enable     <= (mode_nxt == LMS_NORMAL);
      diag_enable    <= (mode_nxt != LMS_STANDBY);
      cs_low_ron     <= (mode_nxt == LMS_FAIL);
    end
  end

  // Core supply, resets and register-file controls
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      core_enable     <= 1'b0;
      cold_reset      <= 1'b0;
      warm_reset      <= 1'b0;
      mode_ctrl_reset <= 1'b0;
      mode_ctrl_wprot <= 1'b0;
      wake_pending    <= 1'b0;
    end else begin
      core_enable     <= (mode_nxt != LMS_STANDBY);
      cold_reset      <= wake_normal;
      warm_reset      <= warm_go;
      mode_ctrl_reset <= into_fail;
      mode_ctrl_wprot <= (mode_nxt == LMS_FAIL);
      wake_pending    <= ~en_s & wake_hold;
    end
  end

endmodule : lms_sequencer

`default_nettype wire

// File: verification/lms_chk.sv
// Port checker for the mode sequencer.
// Assumes it is bound onto lms_sequencer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module lms_chk (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       limp_pin,
  input wire logic       logic_undervoltage,
  input wire logic [7:0] power_outputs,
  input wire logic       core_enable,
  input wire logic       cold_reset,
  input wire logic       warm_reset,
  input wire logic       normal_mode,
  input wire logic       spi_enable,
  input wire logic       pwm_enable,
  input wire logic       cs_low_ron,
  input wire logic       mode_ctrl_reset,
  input wire logic       mode_ctrl_wprot,
  input wire logic       fail_mode_flag
);
  // --------------------------------------------------------------------------
  // Mode relations
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  property p_stby; !core_enable |-> power_outputs == 8'h00; endproperty
  a_stby: assert property (p_stby) else $error("output driven with core off");
  property p_cold; $rose(normal_mode) && !$past(fail_mode_flag) |-> cold_reset && core_enable; endproperty
  a_cold: assert property (p_cold) else $error("no cold reset on wake");
  // Pins reach the mode flop three edges after they change
  property p_wake; $rose(normal_mode) && !$past(fail_mode_flag) |-> !$past(limp_pin, 3) && !$past(logic_undervoltage, 3); endproperty
  a_wake: assert property (p_wake) else $error("wake with limp or undervoltage");
  property p_spi; normal_mode |-> spi_enable && !fail_mode_flag; endproperty
  a_spi: assert property (p_spi) else $error("serial port off in normal");
  property p_lock; fail_mode_flag |-> mode_ctrl_wprot && cs_low_ron && !pwm_enable; endproperty
  a_lock: assert property (p_lock) else $error("fail mode settings wrong");
  property p_mcr; $rose(fail_mode_flag) |-> mode_ctrl_reset; endproperty
  a_mcr: assert property (p_mcr) else $error("mode control not reset on fail entry");
  // One cycle of grace: the output flop may still hold normal drive
  property p_off48; fail_mode_flag && $past(fail_mode_flag) |-> power_outputs[3] == 1'b0 && power_outputs[7] == 1'b0; endproperty
  a_off48: assert property (p_off48) else $error("channel 4 or 8 on in fail");
  property p_warm; warm_reset |-> normal_mode && $past(fail_mode_flag); endproperty
  a_warm: assert property (p_warm) else $error("warm reset outside fail exit");
  property p_exit; $fell(fail_mode_flag) && normal_mode |-> warm_reset; endproperty
  a_exit: assert property (p_exit) else $error("fail exit without warm reset");
  c_cold: cover property (cold_reset);
  c_warm: cover property (warm_reset);
  c_fail: cover property ($rose(fail_mode_flag));
endmodule : lms_chk
`default_nettype wire

// File: verification/lms_host.sv
// Host model: serial frames on a link clock that runs only inside frames.
// Assumes the bench calls frame and that frames follow one another.
`timescale 1ns/10ps
`default_nettype none
module lms_host (
  output var logic clk_link,
  output var logic link_cmd_valid,
  output var logic link_cmd_wd,
  output var logic link_cmd_clear,
  output var logic link_spi_fail
);
  // --------------------------------------------------------------------------
  // Frame driver
  // --------------------------------------------------------------------------
  initial begin
    {clk_link, link_cmd_valid, link_cmd_wd, link_cmd_clear, link_spi_fail} = 5'h00;
  end
  // Two link edges per frame; payload inverted after so no stale value lingers
  task automatic frame(input logic wd, input logic clr, input logic bad);
    link_cmd_valid = !bad;
    link_spi_fail = bad;
    link_cmd_wd = wd;
    link_cmd_clear = clr;
    repeat (2) begin
      #7.5 clk_link = 1'b1;
      link_cmd_valid <= 1'b0;
      link_spi_fail <= 1'b0;
      link_cmd_wd <= !wd;
      link_cmd_clear <= !clr;
      #7.5 clk_link = 1'b0;
    end
    #40; // Gap keeps frames five system cycles apart
  endtask : frame
endmodule : lms_host
`default_nettype wire

// File: verification/led_driver_mode_sequencer_tb.sv
// Bench for lms_sequencer with the host model on the link side.
// Assumes shortened delay parameters; pins change on falling clk_sys.
`timescale 1ns/10ps
`default_nettype none
module led_driver_mode_sequencer_tb;
  // --------------------------------------------------------------------------
  // Signals, design and host
  // --------------------------------------------------------------------------
  logic       clk_sys = 1'b0, reset = 1'b1, enable_pin = 1'b0, limp_pin = 1'b0, logic_undervoltage = 1'b0;
  logic [7:0] direct_drive_inputs = 8'h00, channel_overcurrent = 8'h00, over_temperature_shutdown = 8'h00;
  logic [7:0] normal_out_request = 8'h5a, power_outputs;
  logic [3:0] supply_line_undervoltage = 4'h0, supply_line_overvoltage = 4'h0;
  logic       clk_link, link_cmd_valid, link_cmd_wd, link_cmd_clear, link_spi_fail;
  logic       core_enable, cold_reset, warm_reset, normal_mode, spi_enable, pwm_enable, diag_enable;
  logic       cs_low_ron, mode_ctrl_reset, mode_ctrl_wprot, wake_pending, fail_mode_flag, limp_flag;
  logic       logic_undervoltage_flag, serial_failure_flag, watchdog_check_error_flag, link_fail_mode_flag;
  int         error_cnt = 0, check_count = 0;
  always #4 clk_sys = !clk_sys;
  lms_sequencer #(.LIMP_CYC(20), .WD_TIMEOUT_CYC(50), .RESTART_CYC(30), .TOGGLE_CYC(40)) lms_sequencer_inst (.*);
  lms_host lms_host_inst (.*);
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic chk_out(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_out
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_out(what, {7'h00, exp}, {7'h00, got});
  endtask : chk_bit
  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // Wake refused under limp, then a clean enable edge wakes
  task automatic s_cold();
    chk_bit("core_enable", 1'b0, core_enable);
    limp_pin = 1'b1;
    enable_pin = 1'b1;
    cyc(8);
    chk_bit("normal_mode", 1'b0, normal_mode);
    enable_pin = 1'b0;
    limp_pin = 1'b0;
    cyc(4);
    enable_pin = 1'b1;
    cyc(6);
    chk_bit("normal_mode", 1'b1, normal_mode);
    chk_out("power_outputs", 8'h5a, power_outputs);
  endtask : s_cold
  // No watchdog frames at all, so the timeout must end normal mode
  task automatic s_wd();
    cyc(60);
    chk_bit("fail_mode_flag", 1'b1, fail_mode_flag);
    chk_bit("watchdog_check_error_flag", 1'b1, watchdog_check_error_flag);
    chk_bit("limp_flag", 1'b0, limp_flag);
    chk_bit("diag_enable", 1'b1, diag_enable);
  endtask : s_wd
  // Direct drive, overcurrent restart and a latched thermal trip
  task automatic s_drive();
    direct_drive_inputs = 8'hff;
    cyc(6);
    chk_out("power_outputs", 8'h77, power_outputs);
    channel_overcurrent = 8'h01;
    over_temperature_shutdown = 8'h02;
    cyc(6);
    channel_overcurrent = 8'h00;
    over_temperature_shutdown = 8'h00;
    cyc(10);
    chk_out("power_outputs", 8'h74, power_outputs);
    cyc(30);
    chk_out("power_outputs", 8'h75, power_outputs);
  endtask : s_drive
  // Clear, watchdog 0, watchdog 1, then a serial failure
  task automatic s_exit();
    direct_drive_inputs = 8'h00;
    lms_host_inst.frame(1'b1, 1'b1, 1'b0);
    chk_bit("link_fail_mode_flag", 1'b1, link_fail_mode_flag);
    chk_bit("watchdog_check_error_flag", 1'b0, watchdog_check_error_flag);
    lms_host_inst.frame(1'b0, 1'b0, 1'b0);
    lms_host_inst.frame(1'b1, 1'b0, 1'b0);
    cyc(2);
    chk_bit("normal_mode", 1'b1, normal_mode);
    chk_out("power_outputs", 8'h5a, power_outputs);
    lms_host_inst.frame(1'b0, 1'b0, 1'b1);
    cyc(1);
    chk_bit("serial_failure_flag", 1'b1, serial_failure_flag);
    chk_bit("fail_mode_flag", 1'b1, fail_mode_flag);
  endtask : s_exit
  // Enable drops after an input pulse; the monostable holds, then standby
  task automatic s_stby();
    direct_drive_inputs = 8'h01;
    cyc(6);
    direct_drive_inputs = 8'h00;
    enable_pin = 1'b0;
    cyc(10);
    chk_bit("wake_pending", 1'b1, wake_pending);
    cyc(50);
    chk_bit("core_enable", 1'b0, core_enable);
  endtask : s_stby
  // Limp past its settling time, then a line fault held off until it clears
  task automatic s_limp();
    enable_pin = 1'b1;
    cyc(6);
    limp_pin = 1'b1;
    cyc(26);
    chk_bit("limp_flag", 1'b1, limp_flag);
    chk_bit("fail_mode_flag", 1'b1, fail_mode_flag);
    direct_drive_inputs = 8'h01;
    supply_line_undervoltage = 4'h1;
    cyc(40);
    chk_out("power_outputs", 8'h00, power_outputs);
    supply_line_undervoltage = 4'h0;
    cyc(36);
    chk_out("power_outputs", 8'h01, power_outputs);
  endtask : s_limp
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    cyc(20);
    reset = 1'b0;
    cyc(2);
    s_cold();
    s_wd();
    s_drive();
    s_exit();
    s_stby();
    s_limp();
    tally_and_finish();
  end
endmodule : led_driver_mode_sequencer_tb
bind lms_sequencer lms_chk lms_chk_inst (.*);
`default_nettype wire
